/* File: design/csad_decoder.sv */
// Local bus address decoder for one processing subsystem
// Summary of operation
// R01 - Instruction memory at 0x0, data memory at 0x00400000, direct, no local bus.
// R02 - Unbuffered peripheral windows: comms 0x10, timer 0x11, irq unit 0x1f.
// R03 - Buffered peripheral aliases: comms 0x20, timer 0x21, irq unit 0x2f.
// R04 - DMA registers at 0x30000000 unbuffered and 0x40000000 buffered.
// R05 - Unallocated ranges answer with a bus error.
// R06 - SDRAM buffered at 0x60000000, unbuffered at 0x70000000.
// R07 - Buffered system peripherals at 16 Mbyte steps 0xe0000000 to 0xe6000000.
// R08 - Same peripherals unbuffered from 0xf0000000 to 0xf6000000.
// R09 - Boot area 0xff000000, high vectors 0xffff0000, irq unit alias 0xfffff000.
// R10 - All non-local-memory regions go through the one local bus master port.
// R11 - SDRAM and system peripherals are reached through the DMA path.
// R12 - Local-only regions are invisible to DMA and neighbour packets.
// R13 - DMA still reaches both local memories through its second port.
// R14 - Remote bottom 16 Mbyte aliases system RAM repeatedly.
// R15 - High vectors selected after reset until software picks low vectors.
// R16 - Buffered writes acknowledge early; unbuffered wait for target acceptance.
// R17 - Unallocated access gets two-cycle ERROR, no target selected.
module csad_decoder
   import csad_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Processor request (address phase)
   input wire csad_req_t cpu_req,
   input wire logic cpu_lowvec_sel,
   // Processor response
   output logic cpu_ready_ff,
   output logic [1:0] cpu_resp_ff,
   output logic cpu_hivec_ff,
   // Local memory port of the core
   output logic lm_sel_ff,
   output logic lm_data_ff,
   output logic [31:0] lm_addr_ff,
   output logic lm_write_ff,
   // Target side of the bus master port
   output csad_tgt_req_t tgt_req_ff,
   output logic tgt_valid_ff,
   output logic tgt_via_dma_ff,
   input wire logic tgt_accept,
   // DMA second port to the local memories
   input wire logic dma_lm_valid,
   input wire logic [31:0] dma_lm_addr,
   input wire logic dma_lm_data,
   output logic dma_lm_grant_ff,
   // Remote requests (DMA or neighbour packets)
   input wire logic rem_valid,
   input wire logic [31:0] rem_addr,
   output logic rem_valid_ff,
   output logic [31:0] rem_addr_ff,
   output logic rem_err_ff
);

   csad_dec_t cpu_dec;
   csad_dec_t rem_dec;
   csad_st_t st_ff, nxt_st;
   logic nxt_ready, nxt_lm_sel, nxt_lm_data, nxt_lm_write, nxt_tgt_valid;
   logic nxt_via_dma, nxt_hivec, nxt_dma_grant, nxt_rem_valid, nxt_rem_err;
   logic [1:0] nxt_resp;
   logic [31:0] nxt_lm_addr, nxt_rem_addr;
   csad_tgt_req_t nxt_tgt_req;
   logic req_live;

   // Processor view of the map
   csad_map u_cpu_map (
      .addr(cpu_req.addr),
      .remote(1'b0),
      .dec(cpu_dec)
   );

   // Restricted view for DMA and neighbour packets
   csad_map u_rem_map (
      .addr(rem_addr),
      .remote(1'b1),
      .dec(rem_dec)
   );

   assign req_live = cpu_req.trans[1];

   // Processor transfer sequencing
   always_comb begin
      nxt_st = st_ff;
      nxt_ready = cpu_ready_ff;
      nxt_resp = cpu_resp_ff;
      nxt_lm_sel = 1'b0;
      nxt_lm_data = lm_data_ff;
      nxt_lm_addr = lm_addr_ff;
      nxt_lm_write = lm_write_ff;
      nxt_tgt_valid = 1'b0;
      nxt_tgt_req = tgt_req_ff;
      nxt_via_dma = tgt_via_dma_ff;
      nxt_dma_grant = 1'b0;
      case (st_ff)
         ST_IDLE: begin
            nxt_ready = 1'b1;
            nxt_resp = RESP_OKAY;
            if (req_live && cpu_dec.err) begin
               // No target strobe on an unallocated address
               nxt_ready = 1'b0; // R05 R17
               nxt_resp = RESP_ERROR; // R17
               nxt_st = ST_ERR1;
            end else if (req_live && (cpu_dec.tgt == TGT_ILM || cpu_dec.tgt == TGT_DLM)) begin
               // Direct memory path, answered in one cycle
               nxt_lm_sel = 1'b1; // R01
               nxt_lm_data = (cpu_dec.tgt == TGT_DLM);
               nxt_lm_addr = cpu_req.addr;
               nxt_lm_write = cpu_req.write;
            end else if (req_live) begin
               // Everything else leaves on the single master port
               nxt_tgt_valid = 1'b1; // R10
               nxt_tgt_req = '{addr: cpu_req.addr, write: cpu_req.write,
                               buffered: cpu_dec.buffered, tgt: cpu_dec.tgt};
               nxt_via_dma = cpu_dec.via_dma; // R11
               // Buffered writes are acked at once, the rest wait
               if (!(cpu_req.write && cpu_dec.buffered)) begin // R16
                  nxt_ready = 1'b0;
                  nxt_st = ST_WAIT;
               end
            end
            if (!nxt_lm_sel && dma_lm_valid) begin
               // DMA second port uses idle local memory cycles
               nxt_dma_grant = 1'b1; // R13
               nxt_lm_sel = 1'b1;
               nxt_lm_data = dma_lm_data;
               nxt_lm_addr = dma_lm_addr;
               nxt_lm_write = 1'b0;
            end
         end
         ST_WAIT: begin
            // Hold the request until the target takes it
            nxt_tgt_valid = !tgt_accept;
            if (tgt_accept) begin // R16
               nxt_ready = 1'b1;
               nxt_st = ST_IDLE;
            end
         end
         ST_ERR1: begin
            // Second cycle of the error answer
            nxt_ready = 1'b1; // R17
            nxt_st = ST_ERR2;
         end
         ST_ERR2: begin
            nxt_resp = RESP_OKAY;
            nxt_st = ST_IDLE;
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
      // A DMA request only takes the memory when the core does not
      if (st_ff != ST_IDLE && dma_lm_valid) begin // R13
         nxt_dma_grant = 1'b1;
         nxt_lm_sel = 1'b1;
         nxt_lm_data = dma_lm_data;
         nxt_lm_addr = dma_lm_addr;
         nxt_lm_write = 1'b0;
      end
   end

   // Vector base: high after reset until software selects low
   always_comb begin
      nxt_hivec = !cpu_lowvec_sel; // R15
   end

   // Remote view decode; local-only space maps into system RAM or errors
   always_comb begin
      nxt_rem_valid = rem_valid;
      nxt_rem_err = rem_valid && rem_dec.err; // R12
      nxt_rem_addr = SYSRAM_B_BASE + (rem_addr & ALIAS_MASK); // R14
   end

   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= ST_IDLE;
         cpu_ready_ff <= 1'b1;
         cpu_resp_ff <= RESP_OKAY;
         cpu_hivec_ff <= 1'b1;
         lm_sel_ff <= 1'b0;
         lm_data_ff <= 1'b0;
         lm_addr_ff <= 32'h0000_0000;
         lm_write_ff <= 1'b0;
         tgt_req_ff <= '0;
         tgt_valid_ff <= 1'b0;
         tgt_via_dma_ff <= 1'b0;
         dma_lm_grant_ff <= 1'b0;
         rem_valid_ff <= 1'b0;
         rem_addr_ff <= 32'h0000_0000;
         rem_err_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cpu_ready_ff <= nxt_ready;
         cpu_resp_ff <= nxt_resp;
         cpu_hivec_ff <= nxt_hivec;
         lm_sel_ff <= nxt_lm_sel;
         lm_data_ff <= nxt_lm_data;
         lm_addr_ff <= nxt_lm_addr;
         lm_write_ff <= nxt_lm_write;
         tgt_req_ff <= nxt_tgt_req;
         tgt_valid_ff <= nxt_tgt_valid;
         tgt_via_dma_ff <= nxt_via_dma;
         dma_lm_grant_ff <= nxt_dma_grant;
         rem_valid_ff <= nxt_rem_valid;
         rem_addr_ff <= nxt_rem_addr;
         rem_err_ff <= nxt_rem_err;
      end
   end

endmodule // csad_decoder

/* File: include/csad_pkg.sv */
// Address map constants, target codes and carrier structs for the subsystem decoder
package csad_pkg;

   // Region base addresses
   localparam logic [31:0] ILM_BASE = 32'h0000_0000;
   localparam logic [31:0] DLM_BASE = 32'h0040_0000;
   localparam logic [31:0] COMM_U_BASE = 32'h1000_0000;
   localparam logic [31:0] CTIM_U_BASE = 32'h1100_0000;
   localparam logic [31:0] VIU_U_BASE = 32'h1f00_0000;
   localparam logic [31:0] COMM_B_BASE = 32'h2000_0000;
   localparam logic [31:0] CTIM_B_BASE = 32'h2100_0000;
   localparam logic [31:0] VIU_B_BASE = 32'h2f00_0000;
   localparam logic [31:0] DMA_U_BASE = 32'h3000_0000;
   localparam logic [31:0] DMA_B_BASE = 32'h4000_0000;
   localparam logic [31:0] HOLE_A_BASE = 32'h5000_0000;
   localparam logic [31:0] SDRAM_B_BASE = 32'h6000_0000;
   localparam logic [31:0] SDRAM_U_BASE = 32'h7000_0000;
   localparam logic [31:0] HOLE_B_BASE = 32'h8000_0000;
   localparam logic [31:0] SNOC_B_BASE = 32'he000_0000;
   localparam logic [31:0] SNOC_B_LAST = 32'he600_0000;
   localparam logic [31:0] HOLE_C_BASE = 32'he700_0000;
   localparam logic [31:0] SNOC_U_BASE = 32'hf000_0000;
   localparam logic [31:0] SNOC_U_LAST = 32'hf600_0000;
   localparam logic [31:0] BOOT_BASE = 32'hff00_0000;
   localparam logic [31:0] HIVEC_BASE = 32'hffff_0000;
   localparam logic [31:0] VIU_H_BASE = 32'hffff_f000;

   // Local-memory window extents
   localparam logic [31:0] ILM_LAST = 32'h003f_ffff;
   localparam logic [31:0] DLM_LAST = 32'h00ff_ffff;
   // Remote view: system RAM repeats across the bottom 16 Mbyte
   localparam logic [31:0] ALIAS_LAST = 32'h00ff_ffff;
   localparam logic [31:0] ALIAS_MASK = 32'h00ff_ffff;
   localparam logic [31:0] SYSRAM_B_BASE = 32'he500_0000;

   // Response and transfer codes on the local bus
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_ERROR = 2'h1;
   localparam logic [1:0] TRANS_IDLE = 2'h0;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;

   // Targets selected by the decoder
   typedef enum logic [4:0] {
      TGT_NONE = 5'h00,
      TGT_ILM = 5'h01,
      TGT_DLM = 5'h02,
      TGT_COMM = 5'h03,
      TGT_CTIM = 5'h04,
      TGT_VIU = 5'h05,
      TGT_DMA = 5'h06,
      TGT_SDRAM = 5'h07,
      TGT_SNOC0 = 5'h08,
      TGT_SNOC1 = 5'h09,
      TGT_SNOC2 = 5'h0a,
      TGT_SNOC3 = 5'h0b,
      TGT_SNOC4 = 5'h0c,
      TGT_SNOC5 = 5'h0d,
      TGT_SNOC6 = 5'h0e,
      TGT_BOOT = 5'h0f,
      TGT_HIVEC = 5'h10
   } csad_tgt_t;

   // Result of one decode
   typedef struct packed {
      csad_tgt_t tgt;
      logic buffered;
      logic err;
      logic via_dma;
   } csad_dec_t;

   // Request from the processor
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] trans;
      logic write;
   } csad_req_t;

   // Request to a selected target
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic buffered;
      csad_tgt_t tgt;
   } csad_tgt_req_t;

   // Response bus states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_ERR1 = 2'b11,
      ST_ERR2 = 2'b10
   } csad_st_t;

endpackage : csad_pkg

/* File: design/csad_map.sv */
// Pure combinational address map for the processor and remote views
module csad_map
   import csad_pkg::*;
(
   // Address and who asks
   input wire logic [31:0] addr,
   input wire logic remote,
   // Decode result
   output csad_dec_t dec
);

   // Map lookup; first match wins, holes fall through to error
   always_comb begin
      dec = '{tgt: TGT_NONE, buffered: 1'b0, err: 1'b1, via_dma: 1'b0};
      if (remote) begin
         // Local-only regions hidden; bottom window aliases system RAM
         if (addr <= ALIAS_LAST) begin // R12 R14
            dec = '{tgt: TGT_SNOC5, buffered: 1'b0, err: 1'b0, via_dma: 1'b1};
         end
      end else if (addr <= ILM_LAST) begin // R01
         dec = '{tgt: TGT_ILM, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr >= DLM_BASE && addr <= DLM_LAST) begin // R01
         dec = '{tgt: TGT_DLM, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == COMM_U_BASE[31:24]) begin // R02
         dec = '{tgt: TGT_COMM, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == CTIM_U_BASE[31:24]) begin // R02
         dec = '{tgt: TGT_CTIM, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == VIU_U_BASE[31:24]) begin // R02
         dec = '{tgt: TGT_VIU, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == COMM_B_BASE[31:24]) begin // R03
         dec = '{tgt: TGT_COMM, buffered: 1'b1, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == CTIM_B_BASE[31:24]) begin // R03
         dec = '{tgt: TGT_CTIM, buffered: 1'b1, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:24] == VIU_B_BASE[31:24]) begin // R03
         dec = '{tgt: TGT_VIU, buffered: 1'b1, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:28] == DMA_U_BASE[31:28]) begin // R04
         dec = '{tgt: TGT_DMA, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:28] == DMA_B_BASE[31:28]) begin // R04
         dec = '{tgt: TGT_DMA, buffered: 1'b1, err: 1'b0, via_dma: 1'b0};
      end else if (addr[31:28] == SDRAM_B_BASE[31:28]) begin // R06 R11
         dec = '{tgt: TGT_SDRAM, buffered: 1'b1, err: 1'b0, via_dma: 1'b1};
      end else if (addr[31:28] == SDRAM_U_BASE[31:28]) begin // R06 R11
         dec = '{tgt: TGT_SDRAM, buffered: 1'b0, err: 1'b0, via_dma: 1'b1};
      end else if (addr >= SNOC_B_BASE && addr < HOLE_C_BASE) begin // R07 R11
         dec.tgt = csad_tgt_t'(5'(TGT_SNOC0) + {2'h0, addr[26:24]});
         dec.buffered = 1'b1;
         dec.err = 1'b0;
         dec.via_dma = 1'b1;
      end else if (addr >= SNOC_U_BASE && addr <= (SNOC_U_LAST | ALIAS_MASK)) begin // R08 R11
         dec.tgt = csad_tgt_t'(5'(TGT_SNOC0) + {2'h0, addr[26:24]});
         dec.buffered = 1'b0;
         dec.err = 1'b0;
         dec.via_dma = 1'b1;
      end else if (addr >= VIU_H_BASE) begin // R09
         dec = '{tgt: TGT_VIU, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr >= HIVEC_BASE) begin // R09 R15
         dec = '{tgt: TGT_HIVEC, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end else if (addr >= BOOT_BASE) begin // R09
         dec = '{tgt: TGT_BOOT, buffered: 1'b0, err: 1'b0, via_dma: 1'b0};
      end
      // Anything else (0x01-0x0f, 0x12-0x1e, 0x22-0x2e, 0x5, 0x8-0xd, 0xe7-0xef, 0xf7-0xfe) stays an error R05
   end

endmodule // csad_map

/* File: sim/csad_checker.sv */
// Port-level assertions for the subsystem address decoder
module csad_checker
   import csad_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Processor side
   input wire csad_req_t cpu_req,
   input wire logic cpu_ready_ff,
   input wire logic [1:0] cpu_resp_ff,
   // Memory and target side
   input wire logic lm_sel_ff,
   input wire logic lm_data_ff,
   input wire logic [31:0] lm_addr_ff,
   input wire csad_tgt_req_t tgt_req_ff,
   input wire logic tgt_valid_ff,
   input wire logic tgt_via_dma_ff,
   input wire logic tgt_accept,
   // Remote view
   input wire logic rem_valid,
   input wire logic [31:0] rem_addr,
   input wire logic rem_valid_ff,
   input wire logic [31:0] rem_addr_ff,
   input wire logic rem_err_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Only requests taken while idle with an OKAY bus count
   wire logic take = cpu_ready_ff && cpu_resp_ff == RESP_OKAY && cpu_req.trans[1];
   wire logic ubw = tgt_valid_ff && !(tgt_req_ff.buffered && tgt_req_ff.write);

   a_err_two_cycle:
   assert property (take && cpu_req.addr[31:28] == 4'h5 |=> !cpu_ready_ff
      && cpu_resp_ff == RESP_ERROR ##1 cpu_ready_ff && cpu_resp_ff == RESP_ERROR)
      else $error("bad error response");
   a_err_no_tgt:
   assert property (cpu_resp_ff == RESP_ERROR |-> !tgt_valid_ff)
      else $error("target on error");
   a_instr_local:
   assert property (take && cpu_req.addr < DLM_BASE |=> lm_sel_ff && !lm_data_ff
      && !tgt_valid_ff && lm_addr_ff == $past(cpu_req.addr))
      else $error("instr memory miss");
   a_buf_early:
   assert property (tgt_valid_ff && tgt_req_ff.buffered && tgt_req_ff.write |-> cpu_ready_ff)
      else $error("buffered write stalled");
   a_unbuf_hold:
   assert property (ubw && !tgt_accept |-> !cpu_ready_ff ##1 tgt_valid_ff && $stable(tgt_req_ff))
      else $error("request dropped");
   a_via_dma:
   assert property (tgt_valid_ff && tgt_req_ff.tgt inside {[TGT_SDRAM:TGT_SNOC6]}
      |-> tgt_via_dma_ff)
      else $error("not via dma");
   a_rem_alias:
   assert property (rem_valid && rem_addr <= ALIAS_LAST |=> rem_valid_ff && !rem_err_ff
      && rem_addr_ff == (SYSRAM_B_BASE | ($past(rem_addr) & ALIAS_MASK)))
      else $error("remote alias wrong");
   a_rem_block:
   assert property (rem_valid && rem_addr > ALIAS_LAST |=> rem_valid_ff && rem_err_ff)
      else $error("remote not blocked");
endmodule // csad_checker

bind csad_decoder csad_checker u_chk (.core_clk, .rst, .cpu_req, .cpu_ready_ff,
   .cpu_resp_ff, .lm_sel_ff, .lm_data_ff, .lm_addr_ff, .tgt_req_ff, .tgt_valid_ff,
   .tgt_via_dma_ff, .tgt_accept, .rem_valid, .rem_addr, .rem_valid_ff, .rem_addr_ff,
   .rem_err_ff);

/* File: sim/csad_tgt_model.sv */
// Target-side responder behind the decoder's bus master port
module csad_tgt_model
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Request and chosen latency
   input wire logic tgt_valid_ff,
   input wire logic [3:0] lat,
   // Acceptance
   output logic tgt_accept
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_ff;
   // Count cycles a request has waited
   always_ff @(posedge core_clk) begin
      if (rst || !tgt_valid_ff || tgt_accept) wait_ff <= 4'h0;
      else wait_ff <= wait_ff + 4'h1;
   end
   // Low when nothing stands, so a stale accept cannot leak
   assign tgt_accept = tgt_valid_ff && (wait_ff >= lat);
endmodule // csad_tgt_model

/* File: sim/tb_top.sv */
// Self-checking testbench for the subsystem address decoder
module tb_top
   import csad_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   csad_req_t cpu_req = '0;
   logic cpu_lowvec_sel = 1'b0;
   logic dma_lm_valid = 1'b0;
   logic [31:0] dma_lm_addr = '0;
   logic dma_lm_data = 1'b0;
   logic rem_valid = 1'b0;
   logic [31:0] rem_addr = '0;
   logic [3:0] lat = 4'h0;
   logic cpu_ready_ff, cpu_hivec_ff, lm_sel_ff, lm_data_ff, lm_write_ff;
   logic [1:0] cpu_resp_ff;
   logic [31:0] lm_addr_ff, rem_addr_ff;
   csad_tgt_req_t tgt_req_ff;
   logic tgt_valid_ff, tgt_via_dma_ff, tgt_accept, dma_lm_grant_ff, rem_valid_ff, rem_err_ff;
   int miscompares = 0;
   int num_checks = 0;

   // 10 MHz clock
   always #50 core_clk = ~core_clk;

   csad_decoder DUT (.core_clk, .rst, .cpu_req, .cpu_lowvec_sel, .cpu_ready_ff, .cpu_resp_ff,
      .cpu_hivec_ff, .lm_sel_ff, .lm_data_ff, .lm_addr_ff, .lm_write_ff, .tgt_req_ff,
      .tgt_valid_ff, .tgt_via_dma_ff, .tgt_accept, .dma_lm_valid, .dma_lm_addr,
      .dma_lm_data, .dma_lm_grant_ff, .rem_valid, .rem_addr, .rem_valid_ff, .rem_addr_ff,
      .rem_err_ff);
   csad_tgt_model PTR (.core_clk, .rst, .tgt_valid_ff, .lat, .tgt_accept);

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask

   // One address phase; outputs are sampled just after the edge that takes it
   task automatic issue(input logic [31:0] a, input logic w);
      @(posedge core_clk);
      cpu_req <= '{addr: a, trans: TRANS_NONSEQ, write: w};
      @(posedge core_clk);
      cpu_req.trans <= TRANS_IDLE;
      #1;
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      while (cpu_ready_ff !== 1'b1 && n < 20) begin
         tick;
         n++;
      end
      if (cpu_ready_ff !== 1'b1) begin
         chk(0, "ready timeout");
         wrap_up;
      end
   endtask

   // Write one target address; buffering and path follow the address prefix
   task automatic acc(input logic [31:0] a, input csad_tgt_t t);
      logic b;
      b = a[31:28] inside {4'h2, 4'h4, 4'h6, 4'he};
      issue(a, 1'b1);
      chk(tgt_valid_ff === 1'b1 && tgt_req_ff.tgt === t && lm_sel_ff === 1'b0
         && tgt_req_ff.addr === a && tgt_req_ff.write === 1'b1, "target");
      if (a < BOOT_BASE) begin
         chk(tgt_req_ff.buffered === b && cpu_ready_ff === b, "buffering");
         chk(tgt_via_dma_ff === (a[30:29] == 2'h3), "dma path");
      end
      wait_rdy;
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      cpu_lowvec_sel <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      #1;
   endtask

   task automatic t_vec;
      int n;
      chk(cpu_hivec_ff === 1'b1, "high vectors");
      @(posedge core_clk);
      cpu_lowvec_sel <= 1'b1;
      n = 0;
      do begin
         tick;
         n++;
      end while (cpu_hivec_ff !== 1'b0 && n < 4);
      chk(cpu_hivec_ff === 1'b0, "low vectors");
      if (cpu_hivec_ff !== 1'b0) wrap_up;
   endtask

   task automatic t_map;
      acc(COMM_U_BASE, TGT_COMM);
      acc(32'h10ff_fffc, TGT_COMM);
      acc(CTIM_U_BASE, TGT_CTIM);
      acc(VIU_U_BASE, TGT_VIU);
      acc(COMM_B_BASE, TGT_COMM);
      acc(CTIM_B_BASE, TGT_CTIM);
      acc(VIU_B_BASE, TGT_VIU);
      acc(DMA_U_BASE, TGT_DMA);
      acc(DMA_B_BASE, TGT_DMA);
      acc(SDRAM_B_BASE, TGT_SDRAM);
      acc(32'h7fff_fffc, TGT_SDRAM);
      for (int k = 0; k < 7; k++) begin
         acc(SNOC_B_BASE + {k[7:0], 24'h0}, csad_tgt_t'(TGT_SNOC0 + 5'(k)));
         acc(SNOC_U_BASE + {k[7:0], 24'h0}, csad_tgt_t'(TGT_SNOC0 + 5'(k)));
      end
      acc(BOOT_BASE, TGT_BOOT);
      acc(HIVEC_BASE, TGT_HIVEC);
      acc(VIU_H_BASE, TGT_VIU);
   endtask

   task automatic t_err;
      logic [31:0] e [7] = '{32'h5000_0000, 32'h5fff_fffc, 32'h8000_0000, 32'hdfff_fffc,
         32'he700_0000, 32'hefff_fffc, 32'hf700_0000};
      foreach (e[i]) begin
         issue(e[i], 1'b0);
         chk(cpu_ready_ff === 1'b0 && cpu_resp_ff === RESP_ERROR, "error cycle 1");
         chk(tgt_valid_ff === 1'b0 && lm_sel_ff === 1'b0, "target on error");
         tick;
         chk(cpu_ready_ff === 1'b1 && cpu_resp_ff === RESP_ERROR, "error cycle 2");
         tick;
         chk(cpu_resp_ff === RESP_OKAY, "error too long");
      end
   endtask

   task automatic t_lm;
      issue(32'h003f_fffc, 1'b1);
      chk(lm_sel_ff === 1'b1 && lm_data_ff === 1'b0 && lm_addr_ff === 32'h003f_fffc
         && lm_write_ff === 1'b1 && cpu_ready_ff === 1'b1, "instr memory");
      issue(DLM_BASE, 1'b0);
      chk(lm_sel_ff === 1'b1 && lm_data_ff === 1'b1 && tgt_valid_ff === 1'b0, "data memory");
      @(posedge core_clk);
      dma_lm_valid <= 1'b1;
      dma_lm_addr <= 32'h0040_0100;
      dma_lm_data <= 1'b1;
      @(posedge core_clk);
      dma_lm_valid <= 1'b0;
      #1;
      chk(dma_lm_grant_ff === 1'b1 && lm_sel_ff === 1'b1 && lm_addr_ff === 32'h0040_0100,
         "dma local port");
      // Core and DMA ask in one cycle: core first, DMA the cycle after
      @(posedge core_clk);
      dma_lm_valid <= 1'b1;
      cpu_req <= '{addr: ILM_BASE, trans: TRANS_NONSEQ, write: 1'b0};
      @(posedge core_clk);
      cpu_req.trans <= TRANS_IDLE;
      #1;
      chk(dma_lm_grant_ff === 1'b0 && lm_addr_ff === ILM_BASE, "core wins memory");
      @(posedge core_clk);
      dma_lm_valid <= 1'b0;
      #1;
      chk(dma_lm_grant_ff === 1'b1 && lm_addr_ff === 32'h0040_0100, "dma after core");
   endtask

   task automatic rem(input logic [31:0] a, input logic [31:0] x, input logic er);
      @(posedge core_clk);
      rem_valid <= 1'b1;
      rem_addr <= a;
      @(posedge core_clk);
      rem_valid <= 1'b0;
      #1;
      chk(rem_valid_ff === 1'b1 && rem_err_ff === er && (er || rem_addr_ff === x), "remote");
   endtask

   task automatic t_slow;
      lat <= 4'h5;
      acc(CTIM_U_BASE, TGT_CTIM);
      issue(SDRAM_B_BASE, 1'b0);
      chk(cpu_ready_ff === 1'b0 && tgt_valid_ff === 1'b1 && tgt_req_ff.write === 1'b0,
         "buffered read");
      // DMA may use the local memories while the core waits on a target
      @(posedge core_clk);
      dma_lm_valid <= 1'b1;
      @(posedge core_clk);
      dma_lm_valid <= 1'b0;
      #1;
      chk(dma_lm_grant_ff === 1'b1 && cpu_ready_ff === 1'b0, "dma while waiting");
      wait_rdy;
      lat <= 4'h0;
   endtask

   // Main sequence
   initial begin
      do_reset;
      t_vec;
      $display("vector test done");
      t_map;
      $display("map test done");
      t_err;
      $display("error test done");
      t_lm;
      $display("local memory test done");
      rem(32'h0000_1234, 32'he500_1234, 1'b0);
      rem(32'h00ff_fffc, 32'he5ff_fffc, 1'b0);
      rem(32'h0100_0000, 32'h0, 1'b1);
      rem(COMM_U_BASE, 32'h0, 1'b1);
      rem(DMA_U_BASE, 32'h0, 1'b1);
      $display("remote test done");
      t_slow;
      $display("slow target test done");
      do_reset;
      t_vec;
      $display("second reset test done");
      wrap_up;
   end
endmodule // tb_top
